// [hw/mfs_pkg.sv]
// Constants for the MAC flow, frame size and status register group
`default_nettype none
package mfs_pkg;
	// ------------------------------------------------
	// Bus and register map
	// ------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFS_JAM_STATUS = 5'h17;
	localparam logic [4:0] OFS_MFS_LOW    = 5'h18;
	localparam logic [4:0] OFS_MFS_HIGH   = 5'h19;
	localparam logic [4:0] OFS_FLOW       = 5'h1a;
	localparam logic [4:0] OFS_MAC_CFG    = 5'h1b;
	// ------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------
	localparam int JAM_W  = 6;
	localparam int MFS_W  = 11;
	localparam int HWP_W  = 6;
	localparam int BIT_FLOW_EN   = 7;
	localparam int BIT_BP_EN     = 6;
	localparam int BIT_DUPLEX    = 7;
	localparam int BIT_NO_LEAK   = 6;
	localparam int BIT_B2B       = 5;
	localparam int BIT_BIG_END   = 7;
	localparam int BIT_RDMA      = 6;
	localparam int BIT_RD_RDY    = 5;
	localparam int BIT_DEV_RDY   = 4;
	localparam int BIT_SPEED     = 2;
	localparam int BIT_PHY_DUP   = 1;
	localparam int BIT_LINK      = 0;
	localparam logic [5:0]  JAM_RESET  = 6'h19;
	localparam logic [10:0] MFS_RESET  = 11'h600;
	localparam logic [5:0]  HWP_RESET  = 6'h07;
	// Transmit tracking states
	typedef enum logic [0:0] {
		MFS_TX_IDLE = 1'b0,
		MFS_TX_BUSY = 1'b1
	} mfs_tx_e;
endpackage
`default_nettype wire

// [hw/mfs_status_if.sv]
// Carrier for the device status byte between status builder and registers
`default_nettype none
interface mfs_status_if;
	logic [7:0] status_byte;  // Assembled status, bit 3 zero
	logic       phy_full_dup; // Synchronised PHY duplex
	// Builder drives, register block reads
	modport builder (output status_byte, output phy_full_dup);
	modport user    (input status_byte, input phy_full_dup);
endinterface
`default_nettype wire

// [hw/mfs_status.sv]
// Device status byte builder with PHY pin synchronisers
`default_nettype none
module mfs_status
	import mfs_pkg::*;
(
	// Clock and reset
	input  wire logic   clock,
	input  wire logic   resetn,
	// PHY pins, asynchronous
	input  wire logic   phy_speed_100,
	input  wire logic   phy_full_duplex,
	input  wire logic   phy_link_up,
	// Same-clock status sources
	input  wire logic   byte_order_nonzero,
	input  wire logic   remote_dma_done,
	input  wire logic   read_port_ready,
	input  wire logic   device_ready,
	// Status out
	mfs_status_if.builder st
);
	// ------------------------------------------------
	// Two-stage synchronisers for the PHY pins
	// ------------------------------------------------
	logic [2:0] sync1_reg; // First stage, read only by the second
	logic [2:0] sync2_reg; // Stable copy
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= {phy_speed_100, phy_full_duplex, phy_link_up};
			sync2_reg <= sync1_reg;
		end
	end
	// ------------------------------------------------
	// Status byte: pure wiring, so reads have no effect
	// ------------------------------------------------
	always_comb begin
		st.status_byte = 8'h00;                          // Bit 3 stays zero
		st.status_byte[BIT_BIG_END] = byte_order_nonzero;
		st.status_byte[BIT_RDMA]    = remote_dma_done;
		st.status_byte[BIT_RD_RDY]  = read_port_ready;
		st.status_byte[BIT_DEV_RDY] = device_ready;
		st.status_byte[BIT_SPEED]   = sync2_reg[2];
		st.status_byte[BIT_PHY_DUP] = sync2_reg[1];
		st.status_byte[BIT_LINK]    = sync2_reg[0];
	end
	assign st.phy_full_dup = sync2_reg[1];
endmodule
`default_nettype wire

// [hw/mfs_regs.sv]
// Flow control, frame size and device status registers of the MAC
`default_nettype none
module mfs_regs
	import mfs_pkg::*;
(
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      resetn,
	// Host register port, same clock
	input  wire logic [mfs_pkg::ADDR_W-1:0] host_addr,
	input  wire logic [7:0]                host_wdata,
	input  wire logic                      host_cs,
	input  wire logic                      host_wr,
	input  wire logic                      host_rd,
	output logic [7:0]                     host_rdata,
	// PHY pins, asynchronous
	input  wire logic                      phy_speed_100,
	input  wire logic                      phy_full_duplex,
	input  wire logic                      phy_link_up,
	// Device state, same clock
	input  wire logic [7:0]                byte_order_value,
	input  wire logic                      remote_dma_done,
	input  wire logic                      read_port_ready,
	input  wire logic                      power_saving,
	input  wire logic                      eeprom_loading,
	input  wire logic                      tx_config_duplex,
	input  wire logic                      internal_phy_sel,
	// Transmit handshake
	input  wire logic                      tx_request,
	input  wire logic                      tx_done,
	output logic                           tx_accept,
	// Settings to the MAC
	output logic [mfs_pkg::JAM_W-1:0]      jam_limit_count,
	output logic [mfs_pkg::MFS_W-1:0]      max_frame_size,
	output logic                           flow_control_enable,
	output logic                           back_pressure_active,
	output logic [mfs_pkg::HWP_W-1:0]      high_water_pages,
	output logic                           mac_full_duplex,
	output logic                           leakage_enable,
	output logic                           back_to_back_tx_control,
	output logic                           device_ready
);
	import mfs_pkg::*;

	// ------------------------------------------------
	// Decode
	// ------------------------------------------------
	logic wr_hit; // Write strobe this cycle
	logic rd_hit; // Read strobe this cycle
	assign wr_hit = host_cs & host_wr;
	assign rd_hit = host_cs & host_rd;

	// ------------------------------------------------
	// Storage
	// ------------------------------------------------
	logic [JAM_W-1:0] jam_reg;     // Jam limit count
	logic [MFS_W-1:0] mfs_reg;     // Max frame size
	logic             flow_en_reg; // Flow control enable
	logic             bp_en_reg;   // Half-duplex back pressure
	logic [HWP_W-1:0] hwp_reg;     // High-water pages
	logic             dup_wr_reg;  // Written duplex bit
	logic             no_leak_reg; // Leakage off when set
	logic             b2b_reg;     // Back-to-back transmit
	logic             ready_reg;   // Device ready
	logic [7:0]       rdata_reg;   // Read data
	mfs_tx_e          tx_reg;      // Transmit in flight

	// Status byte from the builder
	mfs_status_if st ();

	mfs_status u_status (
		.clock              (clock),
		.resetn             (resetn),
		.phy_speed_100      (phy_speed_100),
		.phy_full_duplex    (phy_full_duplex),
		.phy_link_up        (phy_link_up),
		.byte_order_nonzero (|byte_order_value),
		.remote_dma_done    (remote_dma_done),
		.read_port_ready    (read_port_ready),
		.device_ready       (ready_reg),
		.st                 (st.builder)
	);

	// ------------------------------------------------
	// Jam limit: write only, shares offset with status
	// ------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			jam_reg <= JAM_RESET;
		end else if (wr_hit && host_addr == OFS_JAM_STATUS) begin
			// Upper two bits are dropped; status is not writable
			jam_reg <= host_wdata[JAM_W-1:0];
		end
	end

	// ------------------------------------------------
	// Max frame size, split low and high
	// ------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mfs_reg <= MFS_RESET;
		end else if (wr_hit && host_addr == OFS_MFS_LOW) begin
			mfs_reg[7:0] <= host_wdata;
		end else if (wr_hit && host_addr == OFS_MFS_HIGH) begin
			// Only three bits exist above the low byte
			mfs_reg[10:8] <= host_wdata[2:0];
		end
	end

	// ------------------------------------------------
	// Flow control register
	// ------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			flow_en_reg <= 1'b0;
			bp_en_reg   <= 1'b0;
			hwp_reg     <= HWP_RESET;
		end else if (wr_hit && host_addr == OFS_FLOW) begin
			flow_en_reg <= host_wdata[BIT_FLOW_EN];
			bp_en_reg   <= host_wdata[BIT_BP_EN];
			hwp_reg     <= host_wdata[HWP_W-1:0];
		end
	end

	// ------------------------------------------------
	// MAC configuration: duplex, leakage, back-to-back
	// ------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dup_wr_reg  <= 1'b0;
			no_leak_reg <= 1'b0; // Leakage allowed by default
			b2b_reg     <= 1'b0;
		end else if (wr_hit && host_addr == OFS_MAC_CFG) begin
			dup_wr_reg  <= host_wdata[BIT_DUPLEX];
			no_leak_reg <= host_wdata[BIT_NO_LEAK];
			b2b_reg     <= host_wdata[BIT_B2B];
		end
	end

	// ------------------------------------------------
	// Effective duplex
	// ------------------------------------------------
	// With the internal PHY the negotiated mode rules and both
	// software bits are ignored; otherwise either bit forces full.
	always_comb begin
		if (internal_phy_sel) begin
			mac_full_duplex = st.phy_full_dup;
		end else begin
			mac_full_duplex = dup_wr_reg | tx_config_duplex;
		end
	end

	// ------------------------------------------------
	// Device ready: low in reset, power save, EEPROM load
	// ------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= ~power_saving & ~eeprom_loading;
		end
	end

	// ------------------------------------------------
	// Transmit tracking for back-to-back control
	// ------------------------------------------------
	// Without back-to-back a second request waits for tx_done;
	// a done in the same cycle as a request frees the slot.
	always_comb begin
		tx_accept = tx_request & (b2b_reg | tx_reg == MFS_TX_IDLE | tx_done);
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tx_reg <= MFS_TX_IDLE;
		end else begin
			case (tx_reg)
				MFS_TX_IDLE: begin
					if (tx_accept) begin
						tx_reg <= MFS_TX_BUSY;
					end
				end
				MFS_TX_BUSY: begin
					// New acceptance wins over a done
					if (tx_done && !tx_accept) begin
						tx_reg <= MFS_TX_IDLE;
					end
				end
				default: begin
					tx_reg <= MFS_TX_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------
	// Read path: one cycle after the strobe, no side effects
	// ------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_reg <= 8'h00;
		end else if (rd_hit) begin
			case (host_addr)
				OFS_JAM_STATUS: begin
					rdata_reg <= st.status_byte;
				end
				OFS_MFS_LOW: begin
					rdata_reg <= mfs_reg[7:0];
				end
				OFS_MFS_HIGH: begin
					rdata_reg <= {5'h00, mfs_reg[10:8]};
				end
				OFS_FLOW: begin
					rdata_reg <= {flow_en_reg, bp_en_reg, hwp_reg};
				end
				OFS_MAC_CFG: begin
					// Reads show the duplex actually in force
					rdata_reg <= {mac_full_duplex, no_leak_reg, b2b_reg, 5'h00};
				end
				default: begin
					rdata_reg <= 8'h00; // Unmapped reads return zero
				end
			endcase
		end
	end

	// ------------------------------------------------
	// Outputs
	// ------------------------------------------------
	assign host_rdata              = rdata_reg;
	assign jam_limit_count         = jam_reg;
	assign max_frame_size          = mfs_reg;
	assign flow_control_enable     = flow_en_reg;
	assign high_water_pages        = hwp_reg;
	assign back_to_back_tx_control = b2b_reg;
	assign device_ready            = ready_reg;
	// Back pressure only counts in half duplex
	assign back_pressure_active = bp_en_reg & ~mac_full_duplex;
	// Leakage after jam_limit_count collisions when not disabled
	assign leakage_enable = ~no_leak_reg;

	// ------------------------------------------------
	// Assertions
	// ------------------------------------------------
	a_jam_write: assert property (@(posedge clock) disable iff (!resetn)
		(wr_hit && host_addr == OFS_JAM_STATUS)
		|=> jam_limit_count == $past(host_wdata[5:0]))
		else $error("jam limit not written");

	a_status_bits: assert property (@(posedge clock) disable iff (!resetn)
		rd_hit && host_addr == OFS_JAM_STATUS
		|=> host_rdata[3] == 1'b0 && host_rdata[4] == $past(ready_reg))
		else $error("status bit 3 or 4 wrong");

	a_big_endian: assert property (@(posedge clock) disable iff (!resetn)
		rd_hit && host_addr == OFS_JAM_STATUS
		|=> host_rdata[7] == ($past(byte_order_value) != 8'h00))
		else $error("byte order bit wrong");

	a_dma_mirror: assert property (@(posedge clock) disable iff (!resetn)
		rd_hit && host_addr == OFS_JAM_STATUS
		|=> host_rdata[6] == $past(remote_dma_done)
		&& host_rdata[5] == $past(read_port_ready))
		else $error("dma or port bit wrong");

	a_ready_busy: assert property (@(posedge clock) disable iff (!resetn)
		(power_saving || eeprom_loading) |=> !device_ready)
		else $error("ready while busy");

	a_frame_high: assert property (@(posedge clock) disable iff (!resetn)
		wr_hit && host_addr == OFS_MFS_HIGH
		|=> max_frame_size[10:8] == $past(host_wdata[2:0])
		&& $stable(max_frame_size[7:0]))
		else $error("frame size high wrong");

	a_bp_full_dup: assert property (@(posedge clock) disable iff (!resetn)
		mac_full_duplex |-> !back_pressure_active)
		else $error("back pressure in full duplex");

	a_flow_write: assert property (@(posedge clock) disable iff (!resetn)
		wr_hit && host_addr == OFS_FLOW
		|=> flow_control_enable == $past(host_wdata[7])
		&& high_water_pages == $past(host_wdata[5:0]))
		else $error("flow control not written");

	a_dup_ext: assert property (@(posedge clock) disable iff (!resetn)
		!internal_phy_sel |-> mac_full_duplex == (dup_wr_reg | tx_config_duplex))
		else $error("external duplex OR wrong");

	a_dup_int: assert property (@(posedge clock) disable iff (!resetn)
		internal_phy_sel && $past(resetn) && $past(resetn, 2)
		|-> mac_full_duplex == $past(phy_full_duplex, 2))
		else $error("internal duplex wrong");

	a_tx_hold: assert property (@(posedge clock) disable iff (!resetn)
		tx_request && !back_to_back_tx_control && tx_reg == MFS_TX_BUSY && !tx_done
		|-> !tx_accept)
		else $error("transmit accepted while busy");

	a_status_ro: assert property (@(posedge clock) disable iff (!resetn)
		wr_hit && host_addr == OFS_JAM_STATUS
		|=> $stable(max_frame_size) && $stable(flow_control_enable)
		&& $stable(high_water_pages) && $stable(back_to_back_tx_control))
		else $error("other registers disturbed by jam write");

	// Low byte write must not touch the three high bits
	a_frame_low: assert property (@(posedge clock) disable iff (!resetn)
		wr_hit && host_addr == OFS_MFS_LOW
		|=> max_frame_size[7:0] == $past(host_wdata)
		&& $stable(max_frame_size[10:8]))
		else $error("frame size low wrong");

	// Written leakage select shows inverted on the leakage output
	a_leak_write: assert property (@(posedge clock) disable iff (!resetn)
		wr_hit && host_addr == OFS_MAC_CFG
		|=> leakage_enable == !$past(host_wdata[BIT_NO_LEAK]))
		else $error("leakage select not written");

	// Config reads return the duplex in force, unused bits zero
	a_cfg_read: assert property (@(posedge clock) disable iff (!resetn)
		rd_hit && host_addr == OFS_MAC_CFG
		|=> host_rdata == {$past(mac_full_duplex), !$past(leakage_enable),
		$past(back_to_back_tx_control), 5'h00})
		else $error("config read wrong");

	// Flow control reads return all three fields
	a_flow_read: assert property (@(posedge clock) disable iff (!resetn)
		rd_hit && host_addr == OFS_FLOW
		|=> host_rdata == {$past(flow_control_enable), $past(bp_en_reg),
		$past(high_water_pages)})
		else $error("flow control read wrong");

	// Ready returns one cycle after the busy sources clear
	a_ready_up: assert property (@(posedge clock) disable iff (!resetn)
		!power_saving && !eeprom_loading |=> device_ready)
		else $error("ready not restored");

	// Read data only moves on a read strobe
	a_rdata_hold: assert property (@(posedge clock) disable iff (!resetn)
		!rd_hit |=> $stable(host_rdata))
		else $error("read data changed without a read");

	c_b2b_tx: cover property (@(posedge clock) disable iff (!resetn)
		tx_accept && back_to_back_tx_control && tx_reg == MFS_TX_BUSY);
	c_status_rd: cover property (@(posedge clock) disable iff (!resetn)
		rd_hit && host_addr == OFS_JAM_STATUS ##1 host_rdata[4]);
	c_bp_active: cover property (@(posedge clock) disable iff (!resetn)
		back_pressure_active);
	c_cfg_full: cover property (@(posedge clock) disable iff (!resetn)
		rd_hit && host_addr == OFS_MAC_CFG ##1 host_rdata[7]);
	c_int_phy: cover property (@(posedge clock) disable iff (!resetn)
		internal_phy_sel && tx_config_duplex && !mac_full_duplex);
endmodule
`default_nettype wire

// [test/mfs_host_model.sv]
// Host CPU model driving the register port of the flow and status block
`default_nettype none
module mfs_host_model
	import mfs_pkg::*;
(
	// Clock
	input  wire logic                       clock,
	// Host strobes and data towards the device
	output logic [mfs_pkg::ADDR_W-1:0]      host_addr,
	output logic [7:0]                      host_wdata,
	output logic                            host_cs,
	output logic                            host_wr,
	output logic                            host_rd,
	// Read data back from the device
	input  wire logic [7:0]                 host_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------
	// Bus cycles
	// ------------------------------------------------
	// Idle bus at time zero
	initial begin
		host_addr  = '0;
		host_wdata = '0;
		host_cs    = 1'b0;
		host_wr    = 1'b0;
		host_rd    = 1'b0;
	end
	// One strobe, held across the taking edge; released lines flip so stale data is useless
	task automatic cycle(input logic [4:0] a, input logic [7:0] d, input logic w);
		@(negedge clock);
		host_addr  = a;
		host_wdata = d;
		host_cs    = 1'b1;
		host_wr    = w;
		host_rd    = !w;
		@(negedge clock);
		host_cs    = 1'b0;
		host_wr    = 1'b0;
		host_rd    = 1'b0;
		host_addr  = ~a;
		host_wdata = ~d;
	endtask
	// Register write
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		cycle(a, d, 1'b1);
	endtask
	// Register read; one extra cycle covers the registered read latency
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		cycle(a, host_wdata, 1'b0);
		@(negedge clock);
		d = host_rdata;
	endtask
	// Poll the ready flag before other accesses, bounded to avoid a hang
	task automatic wait_ready(output logic ok);
		logic [7:0] d;
		ok = 1'b0;
		for (int i = 0; i < 16 && ok !== 1'b1; i++) begin
			rd(OFS_JAM_STATUS, d);
			ok = d[BIT_DEV_RDY];
		end
	endtask
endmodule
`default_nettype wire

// [test/mac_flow_status_config_bench.sv]
// Self-checking bench for the flow control, frame size and status registers
`default_nettype none
module mac_flow_status_config_bench;
	import mfs_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------
	// Signals
	// ------------------------------------------------
	logic clock, resetn, cs, wr, rd, spd, pdup, lnk, rdma, rdrdy, psave, eel, txd, iphy;
	logic req, done, acc, fce, bpa, mfd, leak, b2b, rdy;
	logic [4:0]  addr;
	logic [7:0]  wdata, rdata, bo;
	logic [5:0]  jam, hwp;
	logic [10:0] mfs;
	int          err_total, n_tests, cyc;
	// Device under test with every input driven by the bench or the host
	mfs_regs i_dut (.clock(clock), .resetn(resetn), .host_addr(addr), .host_wdata(wdata),
		.host_cs(cs), .host_wr(wr), .host_rd(rd), .host_rdata(rdata),
		.phy_speed_100(spd), .phy_full_duplex(pdup), .phy_link_up(lnk),
		.byte_order_value(bo), .remote_dma_done(rdma), .read_port_ready(rdrdy),
		.power_saving(psave), .eeprom_loading(eel), .tx_config_duplex(txd),
		.internal_phy_sel(iphy), .tx_request(req), .tx_done(done), .tx_accept(acc),
		.jam_limit_count(jam), .max_frame_size(mfs), .flow_control_enable(fce),
		.back_pressure_active(bpa), .high_water_pages(hwp), .mac_full_duplex(mfd),
		.leakage_enable(leak), .back_to_back_tx_control(b2b), .device_ready(rdy));
	// Host partner on the register port
	mfs_host_model i_host (.clock(clock), .host_addr(addr), .host_wdata(wdata),
		.host_cs(cs), .host_wr(wr), .host_rd(rd), .host_rdata(rdata));
	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	// Clock at 200 MHz
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Read a register and compare
	task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_host.rd(a, d);
		chk(nm, d, e);
	endtask
	// Verdict and end of run
	task automatic end_of_test();
		if (err_total == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc >= 5000) begin
			err_total++;
			end_of_test();
		end
	end
	// One transmit request cycle, accept checked once the inputs settle
	task automatic tx(input logic r, input logic dn, input logic e);
		@(negedge clock);
		req  = r;
		done = dn;
		#1;
		chk("tx_accept", acc, e);
	endtask
	// Apply status sources, wait out the pin synchronisers, read twice
	task automatic st(input logic [7:0] b, input logic [5:0] p, input logic [7:0] e);
		@(negedge clock);
		bo = b;
		{rdma, rdrdy, spd, pdup, lnk} = p[4:0];
		repeat (4) @(negedge clock);
		rchk("status", OFS_JAM_STATUS, e);
		rchk("status again", OFS_JAM_STATUS, e);
	endtask
	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	// Reset values at the outputs and through the bus
	task automatic t_reset();
		chk("ready in reset", rdy, 1'b0);
		@(negedge clock);
		resetn = 1'b1;
		repeat (3) @(negedge clock);
		chk("jam", jam, 6'h19);
		chk("mfs", mfs, 11'd1536);
		chk("fce", fce, 1'b0);
		chk("hwp", hwp, 6'h07);
		chk("leak", leak, 1'b1);
		rchk("mfs low", OFS_MFS_LOW, 8'h00);
		rchk("mfs high", OFS_MFS_HIGH, 8'h06);
		rchk("flow", OFS_FLOW, 8'h07);
		rchk("unmapped", 5'h05, 8'h00);
	endtask
	// Status bits, then a jam write that must leave them alone
	task automatic t_status();
		st(8'h01, 6'h15, 8'hd5); // Big-endian, dma, 100M, link
		st(8'h00, 6'h0a, 8'h32); // Read port ready, full duplex
		i_host.wr(OFS_JAM_STATUS, 8'hea);
		@(negedge clock);
		chk("jam write", jam, 6'h2a);
		rchk("status after jam", OFS_JAM_STATUS, 8'h32);
	endtask
	// Ready drops while power saving or loading
	task automatic t_ready();
		logic ok;
		psave = 1'b1;
		repeat (3) @(negedge clock);
		chk("ready saving", rdy, 1'b0);
		rchk("status saving", OFS_JAM_STATUS, 8'h22);
		psave = 1'b0;
		eel   = 1'b1;
		repeat (3) @(negedge clock);
		rchk("status loading", OFS_JAM_STATUS, 8'h22);
		eel = 1'b0;
		i_host.wait_ready(ok);
		chk("ready back", ok, 1'b1);
	endtask
	// Frame size split, flow bits, duplex merging and leakage
	task automatic t_config();
		i_host.wr(OFS_MFS_LOW, 8'hff);
		i_host.wr(OFS_MFS_HIGH, 8'hfd);
		i_host.wr(OFS_FLOW, 8'hc5);
		i_host.wr(OFS_MAC_CFG, 8'h40);
		@(negedge clock);
		chk("mfs new", mfs, 11'h5ff);
		rchk("mfs high rd", OFS_MFS_HIGH, 8'h05);
		chk("fce on", fce, 1'b1);
		chk("hwp new", hwp, 6'h05);
		chk("bp half", bpa, 1'b1);
		chk("no leak", leak, 1'b0);
		rchk("cfg half", OFS_MAC_CFG, 8'h40);
		txd = 1'b1;
		repeat (2) @(negedge clock);
		chk("dup by tx cfg", mfd, 1'b1);
		chk("bp full", bpa, 1'b0);
		rchk("cfg full", OFS_MAC_CFG, 8'hc0);
		txd = 1'b0;
		i_host.wr(OFS_MAC_CFG, 8'h80);
		@(negedge clock);
		chk("dup by write", mfd, 1'b1);
		iphy = 1'b1;
		txd  = 1'b1;
		pdup = 1'b0; // PHY at half duplex, so both forcing bits must lose
		repeat (2) @(negedge clock);
		chk("dup internal", mfd, 1'b0);
		rchk("cfg internal", OFS_MAC_CFG, 8'h00);
		iphy = 1'b0;
		txd  = 1'b0;
	endtask
	// Transmit tracking with and without back-to-back
	task automatic t_tx();
		tx(1'b1, 1'b0, 1'b1);
		tx(1'b0, 1'b0, 1'b0);
		tx(1'b1, 1'b0, 1'b0); // Refused while busy
		tx(1'b1, 1'b1, 1'b1); // Done frees the slot at once
		tx(1'b0, 1'b1, 1'b0);
		tx(1'b0, 1'b0, 1'b0);
		i_host.wr(OFS_MAC_CFG, 8'h20);
		@(negedge clock);
		chk("b2b", b2b, 1'b1);
		tx(1'b1, 1'b0, 1'b1);
		tx(1'b1, 1'b0, 1'b1); // Accepted without a done
		tx(1'b0, 1'b1, 1'b0);
		tx(1'b0, 1'b0, 1'b0);
	endtask
	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		err_total = 0;
		n_tests   = 0;
		cyc       = 0;
		resetn    = 1'b0;
		{spd, pdup, lnk, rdma, rdrdy, psave, eel, txd, iphy, req, done} = '0;
		bo = 8'h00;
		repeat (8) @(negedge clock);
		t_reset();
		t_status();
		t_ready();
		t_config();
		t_tx();
		end_of_test();
	end
endmodule
`default_nettype wire
